// ===== logic/wbc_pkg.sv
// wbc_pkg: constants and state types for the external cpu block write buffer controller.
// assumes a 64-bit multiplexed address/data bus and one 100 MHz system clock.
`default_nettype none

package wbc_pkg;

  // widths and depth
  localparam int DATA_W   = 64;
  localparam int ADDR_W   = 32;
  localparam int CMD_W    = 9;
  localparam int DEPTH    = 8;
  localparam int PTR_W    = 3;
  localparam int CNT_W    = 4;
  localparam int PAT_W    = 4;
  localparam int BE_W     = 8;
  localparam int DW_SHIFT = 3;   // byte offset bits inside one doubleword

  // command bus fields
  localparam int CMD_DATA_BIT  = 8;   // high on data cycles, low on address cycles
  localparam int CMD_OP_HI     = 7;
  localparam int CMD_OP_LO     = 5;
  localparam int CMD_BLOCK_BIT = 4;   // block transfer when set
  localparam int CMD_LINE_HI   = 1;
  localparam int CMD_LINE_LO   = 0;
  localparam int CMD_SIZE_HI   = 2;
  localparam int CMD_SIZE_LO   = 0;

  localparam logic [2:0] CMD_OP_WRITE = 3'h2;

  // line size codes and doublewords per block
  localparam logic [1:0]       LINE_4W     = 2'h0;
  localparam logic [1:0]       LINE_8W     = 2'h1;
  localparam logic [CNT_W-1:0] BEATS_4W    = 4'h2;
  localparam logic [CNT_W-1:0] BEATS_8W    = 4'h4;
  localparam logic [CNT_W-1:0] BEATS_MAX   = 4'h8;
  localparam logic [CNT_W-1:0] BEATS_ONE   = 4'h1;

  // pacing pattern codes; 0..8 defined, 9..15 reserved
  localparam logic [PAT_W-1:0] PAT_FIRST_RESERVED = 4'h9;

  // reset values
  localparam logic [PAT_W-1:0] PAT_RST       = 4'h0;
  localparam logic [BE_W-1:0]  BE_ALL        = 8'hff;
  localparam logic [ADDR_W-1:0] ADDR_RST     = 32'h0;
  localparam logic             ACCEPT_OFF_B  = 1'b1;   // handshakes are active low

  typedef enum logic [0:0] {P_IDLE, P_DATA}           wbc_proc_e;
  typedef enum logic [1:0] {M_IDLE, M_FETCH, M_WRITE} wbc_mem_e;

endpackage

`default_nettype wire

// ===== logic/wbc_slot_mem.sv
// wbc_slot_mem: eight doubleword storage slots, one write port, registered read port.
// assumes write and read addresses come from the controller on the same clock.
`timescale 1ns/100ps
`default_nettype none

module wbc_slot_mem (
  // clock
  input  wire logic                         ref_clk,
  // write port
  input  wire logic                         wr_en,
  input  wire logic [wbc_pkg::PTR_W-1:0]    wr_slot,
  input  wire logic [wbc_pkg::DATA_W-1:0]   wr_data,
  // read port
  input  wire logic                         rd_en,
  input  wire logic [wbc_pkg::PTR_W-1:0]    rd_slot,
  output logic      [wbc_pkg::DATA_W-1:0]   rd_data_q
);
  import wbc_pkg::*;

  logic [DATA_W-1:0] slot_q [DEPTH];

  // storage has no reset; only slots already written are ever read
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      slot_q[wr_slot] <= wr_data;
    end
  end

  // read data held until the next fetch
  always_ff @(posedge ref_clk) begin
    if (rd_en) begin
      rd_data_q <= slot_q[rd_slot];
    end
  end

endmodule // wbc_slot_mem

`default_nettype wire

// ===== logic/wbc_write_buffer.sv
// wbc_write_buffer: external write buffer between the processor system interface and memory.
// assumes processor bus shares ref_clk, mode strap does not; memory side is same-clock logic.
`timescale 1ns/100ps
`default_nettype none

// Function
// - buffer depth covers worst-case pattern backlog
// - shared address register: reads wait for write
// - overlap variant keeps separate read/write addresses
// - address loads until write command with strobe
// - block address advances in sequential doubleword order
// - separate processor-side and memory-side state machines
// - each arriving doubleword takes a fresh slot
// - stop capturing after last doubleword of block
// - memory side waits out overlapped cache read
// - retire count added to start address makes doubleword address
// - write accept dropped while a transaction is busy or any slot holds data
// - read accept dropped while writing memory
// - capacity matches block size, eight slots
module wbc_write_buffer (
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst_b,
  // processor system interface pins
  input  wire logic [wbc_pkg::CMD_W-1:0]     command_bus,
  input  wire logic                          cpu_drive_strobe_b,
  input  wire logic [wbc_pkg::DATA_W-1:0]    muxed_addr_data_bus,
  output logic                               write_accept_b,
  output logic                               read_accept_b,
  // board straps
  input  wire logic [wbc_pkg::PAT_W-1:0]     pattern_code,
  input  wire logic                          shared_addr_mode,
  output logic                               pattern_reserved,
  // memory side
  input  wire logic                          cache_overlap_busy,
  input  wire logic                          mem_wr_done,
  output logic                               mem_wr_req,
  output logic      [wbc_pkg::ADDR_W-1:0]    mem_addr,
  output logic      [wbc_pkg::BE_W-1:0]      mem_byte_en,
  output logic      [wbc_pkg::DATA_W-1:0]    mem_wr_data
);
  import wbc_pkg::*;

  localparam int SYNC_W = CMD_W + 1 + DATA_W + 1;

  // pin stages: four flops each; only the mode strap waits for stages two and three to agree
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] sync3_q;
  logic [SYNC_W-1:0] pin_q;
  logic [SYNC_W-1:0] pin_d;
  logic [SYNC_W-1:0] agree;

  // bus bits ride the stages as a plain pipeline: they share ref_clk, and waiting for
  // two stages to agree would swallow every single-cycle data beat
  localparam logic [SYNC_W-1:0] BUS_BITS = {1'b0, {(SYNC_W-1){1'b1}}};

  assign agree = ~(sync2_q ^ sync3_q) | BUS_BITS;
  assign pin_d = (sync3_q & agree) | (pin_q & ~agree);

  // strobe and handshakes idle high, everything else low,
  // so the staged strobe cannot fake a command while reset lets go
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= {1'b0, {CMD_W{1'b0}}, 1'b1, {DATA_W{1'b0}}};
      sync2_q <= {1'b0, {CMD_W{1'b0}}, 1'b1, {DATA_W{1'b0}}};
      sync3_q <= {1'b0, {CMD_W{1'b0}}, 1'b1, {DATA_W{1'b0}}};
      pin_q   <= {1'b0, {CMD_W{1'b0}}, 1'b1, {DATA_W{1'b0}}};
    end else begin
      sync1_q <= {shared_addr_mode, command_bus, cpu_drive_strobe_b, muxed_addr_data_bus};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_q   <= pin_d;
    end
  end

  // staged pin fields; the strobe pin is active low, so it is inverted here
  wire              shared_mode = pin_q[SYNC_W-1];
  wire [CMD_W-1:0]  cmd         = pin_q[DATA_W+1 +: CMD_W];
  wire              strobe      = ~pin_q[DATA_W];
  wire [DATA_W-1:0] bus         = pin_q[DATA_W-1:0];

  // command decode
  wire       is_data   = strobe & cmd[CMD_DATA_BIT];
  wire       is_write  = strobe & ~cmd[CMD_DATA_BIT]
                         & (cmd[CMD_OP_HI:CMD_OP_LO] == CMD_OP_WRITE);
  wire       is_block  = cmd[CMD_BLOCK_BIT];
  wire [1:0] line_code = cmd[CMD_LINE_HI:CMD_LINE_LO];
  wire [2:0] size_m1   = cmd[CMD_SIZE_HI:CMD_SIZE_LO];

  // doublewords per block; lines above sixteen words would need cascaded stages
  wire [CNT_W-1:0] blk_beats = (line_code == LINE_4W) ? BEATS_4W :
                               (line_code == LINE_8W) ? BEATS_8W : BEATS_MAX;
  // a single write counts as one beat, so both kinds share the retire path
  wire [CNT_W-1:0] cmd_beats = is_block ? blk_beats : BEATS_ONE;

  // partial writes never straddle, so a shifted mask is enough
  wire [BE_W-1:0] be_base = BE_ALL >> (3'h7 - size_m1);
  wire [BE_W-1:0] be_part = be_base << bus[DW_SHIFT-1:0];
  wire [BE_W-1:0] cmd_be  = is_block ? BE_ALL : be_part;

  // pacing pattern strap, caught once after reset release
  // reserved codes are only flagged; pacing itself is the processor's business
  logic [PAT_W-1:0] pat_q;
  logic             pat_done_q;
  logic             pat_bad_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pat_q      <= PAT_RST;
      pat_done_q <= 1'b0;
      pat_bad_q  <= 1'b0;
    end else if (!pat_done_q) begin
      pat_q      <= pattern_code;
      pat_done_q <= 1'b1;
      pat_bad_q  <= (pattern_code >= PAT_FIRST_RESERVED);
    end
  end

  // shared state between the two machines
  wbc_proc_e          proc_q;
  wbc_proc_e          proc_d;
  wbc_mem_e           mem_q;
  wbc_mem_e           mem_d;
  logic [PTR_W-1:0]   wr_ptr_q;
  logic [PTR_W-1:0]   rd_ptr_q;
  logic [CNT_W-1:0]   occ_q;
  logic [CNT_W-1:0]   beats_q;
  logic [CNT_W-1:0]   cap_cnt_q;
  logic [CNT_W-1:0]   ret_cnt_q;
  logic [ADDR_W-1:0]  wa_q;
  logic [BE_W-1:0]    be_q;
  logic               busy_q;
  logic               busy_d;

  // processor-side machine: address capture and slot filling
  wire capture_gate = (proc_q == P_IDLE) & ~busy_q;
  wire start        = capture_gate & is_write;
  wire push         = (proc_q == P_DATA) & is_data;
  wire last_push    = push & (cap_cnt_q == beats_q - BEATS_ONE);

  // beats past the block length find the machine idle and are dropped
  always_comb begin
    proc_d = proc_q;
    case (proc_q)
      P_IDLE: begin
        if (start) begin
          proc_d = P_DATA;
        end
      end
      P_DATA: begin
        if (last_push) begin
          proc_d = P_IDLE;
        end
      end
      default: proc_d = P_IDLE;
    endcase
  end

  // write address register loads every cycle until the gate drops; it is never
  // shared with reads, so an overlapped read cannot overwrite a captured start
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wa_q <= ADDR_RST;
    end else if (capture_gate) begin
      wa_q <= bus[ADDR_W-1:0];
    end
  end

  // per-transaction size, enables and capture count
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      proc_q    <= P_IDLE;
      beats_q   <= BEATS_ONE;
      be_q      <= BE_ALL;
      cap_cnt_q <= '0;
      wr_ptr_q  <= '0;
    end else begin
      proc_q <= proc_d;
      if (start) begin
        beats_q   <= cmd_beats;
        be_q      <= cmd_be;
        cap_cnt_q <= '0;
      end else if (push) begin
        cap_cnt_q <= cap_cnt_q + BEATS_ONE;
        wr_ptr_q  <= wr_ptr_q + 3'h1;
      end
    end
  end

  // memory-side machine: fetch a slot, present it, wait for memory
  wire             pop      = (mem_q == M_WRITE) & mem_wr_done;
  wire             last_pop = pop & (ret_cnt_q == beats_q - BEATS_ONE);
  wire             fetch    = (mem_q == M_IDLE) & (occ_q != '0) & ~cache_overlap_busy;
  wire [ADDR_W-4:0] dw_base = wa_q[ADDR_W-1:DW_SHIFT];
  wire [ADDR_W-4:0] dw_addr = dw_base + {{(ADDR_W-3-CNT_W){1'b0}}, ret_cnt_q};
  wire [ADDR_W-1:0] ret_addr = {dw_addr, wa_q[DW_SHIFT-1:0]};
  // slot read only on the fetch decision, so presented data holds until done
  wire             slot_rd  = fetch;

  always_comb begin
    mem_d = mem_q;
    case (mem_q)
      M_IDLE: begin
        if (fetch) begin
          mem_d = M_FETCH;
        end
      end
      M_FETCH: mem_d = M_WRITE;
      M_WRITE: begin
        if (pop) begin
          mem_d = M_IDLE;
        end
      end
      default: mem_d = M_IDLE;
    endcase
  end

  // transaction stays busy from address capture until its last slot retires
  // a second command waits on write accept, so one start address is live at a time
  always_comb begin
    busy_d = busy_q;
    if (start) begin
      busy_d = 1'b1;
    end else if (last_pop) begin
      busy_d = 1'b0;
    end
  end

  // retire side pointers and the memory request
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_q       <= M_IDLE;
      rd_ptr_q    <= '0;
      ret_cnt_q   <= '0;
      mem_wr_req  <= 1'b0;
      mem_addr    <= ADDR_RST;
      mem_byte_en <= BE_ALL;
    end else begin
      mem_q <= mem_d;
      if (mem_q == M_FETCH) begin
        mem_wr_req  <= 1'b1;
        mem_addr    <= ret_addr;
        mem_byte_en <= be_q;
      end else if (pop) begin
        mem_wr_req <= 1'b0;
        rd_ptr_q   <= rd_ptr_q + 3'h1;
        ret_cnt_q  <= last_pop ? '0 : ret_cnt_q + BEATS_ONE;
      end
      if (start) begin
        ret_cnt_q <= '0;
      end
    end
  end

  // occupancy and both handshakes; clearing on reset makes the buffer empty
  // a push and a pop in one cycle cancel, so the count tracks live slots exactly
  wire [CNT_W-1:0] occ_d = occ_q + {{(CNT_W-1){1'b0}}, push}
                                 - {{(CNT_W-1){1'b0}}, pop};

  // processor reacts two clocks late, so read accept drops as the fetch starts
  wire ra_off_d = (mem_d != M_IDLE)
                  | (shared_mode & busy_d);
  // one transaction at a time keeps the slot ring from wrapping onto live data
  wire wa_off_d = busy_d | (occ_d != '0);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      occ_q          <= '0;
      busy_q         <= 1'b0;
      write_accept_b <= ACCEPT_OFF_B;
      read_accept_b  <= ACCEPT_OFF_B;
    end else begin
      occ_q          <= occ_d;
      busy_q         <= busy_d;
      write_accept_b <= wa_off_d;
      read_accept_b  <= ra_off_d;
    end
  end

  assign pattern_reserved = pat_bad_q;

  // eight slots sized to a sixteen-word line; no deeper cascade here, but that
  // covers the worst-case backlog of any pacing pattern on such a line
  wbc_slot_mem u_slots (
    .ref_clk   (ref_clk),
    .wr_en     (push),
    .wr_slot   (wr_ptr_q),
    .wr_data   (bus),
    .rd_en     (slot_rd),
    .rd_slot   (rd_ptr_q),
    .rd_data_q (mem_wr_data)
  );

endmodule // wbc_write_buffer

`default_nettype wire

// ===== testbench/wbc_cpu_model.sv
// processor model: write commands and paced block data on the system pins
// assumes the host samples on rising edges; this model moves on falling edges
`timescale 1ns/100ps
`default_nettype none
module wbc_cpu_model (
  // clock
  input  wire logic                      ref_clk,
  // processor system interface
  output logic [wbc_pkg::CMD_W-1:0]      command_bus,
  output logic                           cpu_drive_strobe_b,
  output logic [wbc_pkg::DATA_W-1:0]     muxed_addr_data_bus,
  input  wire logic                      write_accept_b,
  // pacing strap
  input  wire logic [wbc_pkg::PAT_W-1:0] pattern_code
);
  import wbc_pkg::*;
  // pacing by strap code; reserved codes fall back to unpaced
  string pats [9] = '{"D", "DDx", "DDxx", "DxDx", "DDxxx", "DDxxxx", "DxxDxx",
    "DDxxxxxx", "DxxxDxxx"};
  int timeouts = 0;
  initial begin
    command_bus = 9'h0ff;
    cpu_drive_strobe_b = 1'b1;
    muxed_addr_data_bus = 64'h0;
  end
  // released bus toggles so no stale value can pass for data
  task automatic idle();
    @(negedge ref_clk);
    cpu_drive_strobe_b = 1'b1;
    command_bus = ~command_bus;
    muxed_addr_data_bus = ~muxed_addr_data_bus;
  endtask
  task automatic write_op(input logic [8:0] cmd, input logic [31:0] ad, input int nd,
                          input int gap);
    int k;
    int p;
    string s;
    k = 0;
    p = 0;
    s = pats[pattern_code > 4'h8 ? 4'h0 : pattern_code];
    while (write_accept_b !== 1'b0 && k < 900) begin
      idle();
      k++;
    end
    timeouts += (k == 900);
    // caller keeps partials inside one doubleword; address lingers past accept
    repeat (3) begin
      @(negedge ref_clk);
      cpu_drive_strobe_b = 1'b0;
      command_bus = cmd;
      muxed_addr_data_bus = {32'h0, ad};
    end
    repeat (gap) idle();
    // pattern idles fall only between beats, never after the last
    for (int i = 0; i < nd; i++) begin
      while (s[p % s.len()] == "x") begin
        idle();
        p++;
      end
      @(negedge ref_clk);
      cpu_drive_strobe_b = 1'b0;
      command_bus = 9'h100;
      muxed_addr_data_bus = {ad + 32'(8 * i), ~(ad + 32'(8 * i))};
      p++;
    end
    idle();
  endtask
endmodule // wbc_cpu_model
`default_nettype wire

// ===== testbench/wbc_write_buffer_assertions.sv
// checker: timing relations on the write buffer host ports
// assumes one clock domain; bound onto every buffer instance below
`timescale 1ns/100ps
`default_nettype none
module wbc_write_buffer_assertions (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // processor side
  input wire logic        write_accept_b,
  input wire logic        read_accept_b,
  // memory side
  input wire logic        cache_overlap_busy,
  input wire logic        mem_wr_done,
  input wire logic        mem_wr_req,
  input wire logic [31:0] mem_addr,
  input wire logic [7:0]  mem_byte_en,
  input wire logic [63:0] mem_wr_data
);
  import wbc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [1:0]  cnt_q;
  logic        req_q;
  logic        seen_q;
  logic [31:0] prev_q;
  // age since reset and last request start; start memory dropped between transactions
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 2'h0;
      req_q <= 1'b0;
      seen_q <= 1'b0;
      prev_q <= 32'h0;
    end else begin
      cnt_q <= (cnt_q == 2'h3) ? cnt_q : cnt_q + 2'h1;
      req_q <= mem_wr_req;
      seen_q <= (mem_wr_req && !req_q) || (seen_q && write_accept_b);
      prev_q <= (mem_wr_req && !req_q) ? mem_addr : prev_q;
    end
  end
  a_reset_ready: assert property (cnt_q == 2'h2 |-> !write_accept_b)
    else $error("write accept not offered after reset");
  a_req_held: assert property (mem_wr_req && !mem_wr_done |=>
    mem_wr_req && $stable(mem_addr) && $stable(mem_wr_data)) else $error("request moved");
  a_req_drop: assert property (mem_wr_req && mem_wr_done |-> ##[1:2] !mem_wr_req)
    else $error("request kept after done");
  a_be_shape: assert property (mem_wr_req |-> mem_byte_en != 8'h0 &&
    ((mem_byte_en + (mem_byte_en & -mem_byte_en)) & mem_byte_en) == 8'h0)
    else $error("byte enables not contiguous");
  a_busy_hold: assert property ($rose(mem_wr_req) |-> !$past(cache_overlap_busy, 2))
    else $error("write started during cache read");
  a_read_block: assert property ($rose(mem_wr_req) |-> read_accept_b && $past(read_accept_b))
    else $error("reads not held off");
  a_accept_busy: assert property ($rose(mem_wr_req) |-> write_accept_b)
    else $error("writes accepted while buffer in use");
  a_addr_seq: assert property (mem_wr_req && !req_q && seen_q |->
    mem_addr == prev_q + 32'h8 && mem_byte_en == 8'hff) else $error("block address not stepped");
  c_retire: cover property (mem_wr_req && mem_wr_done);
  c_busy_wait: cover property (cache_overlap_busy && write_accept_b);
  c_block_step: cover property (mem_wr_req && !req_q && seen_q);
endmodule // wbc_write_buffer_assertions
bind wbc_write_buffer wbc_write_buffer_assertions u_chk (.ref_clk, .rst_b, .write_accept_b,
  .read_accept_b, .cache_overlap_busy, .mem_wr_done, .mem_wr_req, .mem_addr, .mem_byte_en,
  .mem_wr_data);
`default_nettype wire

// ===== testbench/wbc_write_buffer_tb_top.sv
// bench: processor model, memory responder and row table around the buffer
// assumes the checker binds itself from its own file
`timescale 1ns/100ps
`default_nettype none
module wbc_write_buffer_tb_top;
  import wbc_pkg::*;
  typedef struct {logic [3:0] pat; logic shr; logic blk; logic [2:0] code;
    logic [31:0] ad; int extra; int gap; int dly;} wbc_row_s;
  // pattern, shared, block, line or size, address, extra beats, gap, memory delay
  wbc_row_s rows [12] = '{
    '{4'h0, 1'h0, 1'h1, 3'h0, 32'h1000, 0, 0, 0}, '{4'h1, 1'h0, 1'h1, 3'h1, 32'h2020, 0, 2, 3},
    '{4'h2, 1'h0, 1'h1, 3'h2, 32'h3000, 0, 0, 0}, '{4'h3, 1'h0, 1'h1, 3'h3, 32'h3100, 0, 1, 6},
    '{4'h4, 1'h0, 1'h1, 3'h0, 32'h3200, 1, 0, 0}, '{4'h5, 1'h1, 1'h1, 3'h1, 32'h3300, 0, 0, 1},
    '{4'h6, 1'h0, 1'h1, 3'h2, 32'h3400, 0, 4, 2}, '{4'h7, 1'h0, 1'h1, 3'h1, 32'h3500, 0, 0, 0},
    '{4'h8, 1'h0, 1'h1, 3'h3, 32'h3600, 0, 0, 9}, '{4'h0, 1'h0, 1'h0, 3'h4, 32'h4000, 0, 0, 0},
    '{4'h1, 1'h1, 1'h0, 3'h0, 32'h4007, 0, 3, 2}, '{4'h2, 1'h0, 1'h0, 3'h3, 32'h5004, 0, 0, 0}};
  logic ref_clk, rst_b, pattern_reserved, cache_overlap_busy, shared_addr_mode, mem_wr_done;
  logic mem_wr_req, write_accept_b, read_accept_b, cpu_drive_strobe_b;
  logic [8:0]  command_bus;
  logic [3:0]  pattern_code;
  logic [7:0]  mem_byte_en;
  logic [31:0] mem_addr;
  logic [63:0] muxed_addr_data_bus, mem_wr_data;
  logic [31:0] ret_a [$];
  logic [63:0] ret_d [$];
  logic [7:0]  ret_b [$];
  int n_errors, checks, mdly, mcnt;
  bit mlock;
  wbc_write_buffer uut (.ref_clk, .rst_b, .command_bus, .cpu_drive_strobe_b,
    .muxed_addr_data_bus, .write_accept_b, .read_accept_b, .pattern_code, .shared_addr_mode,
    .pattern_reserved, .cache_overlap_busy, .mem_wr_done, .mem_wr_req, .mem_addr,
    .mem_byte_en, .mem_wr_data);
  wbc_cpu_model cpu (.ref_clk, .command_bus, .cpu_drive_strobe_b, .muxed_addr_data_bus,
    .write_accept_b, .pattern_code);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // memory answers after mdly cycles, one done pulse per request
  always @(negedge ref_clk) begin
    mem_wr_done <= 1'b0;
    if (!mem_wr_req) begin
      mlock = 1'b0;
      mcnt = 0;
    end else if (!mlock && mcnt >= mdly) begin
      mem_wr_done <= 1'b1;
      mlock = 1'b1;
      ret_a.push_back(mem_addr);
      ret_d.push_back(mem_wr_data);
      ret_b.push_back(mem_byte_en);
    end else mcnt++;
  end
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wait_ret(input int n);
    int k;
    k = 0;
    while (ret_a.size() < n && k < 3000) begin
      @(negedge ref_clk);
      k++;
    end
    if (k == 3000) begin
      n_errors++;
      $display("mismatch retired expected %0d seen %0d", n, ret_a.size());
      print_verdict();
    end
  endtask
  // straps are settled during reset; pin sync needs a few clocks after release
  task automatic do_reset(input logic [3:0] pat, input logic shr);
    rst_b = 1'b0;
    pattern_code = pat;
    shared_addr_mode = shr;
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (8) @(negedge ref_clk);
    ret_a.delete();
    ret_d.delete();
    ret_b.delete();
    chk("accept_after_reset", 1'b0, write_accept_b);
    chk("pattern_flag", pat >= PAT_FIRST_RESERVED, pattern_reserved);
  endtask
  task automatic watch_mode(input logic shr);
    int k;
    k = 0;
    while (write_accept_b !== 1'b1 && k < 900) begin
      @(negedge ref_clk);
      k++;
    end
    if (k == 900) begin
      n_errors++;
      $display("mismatch write_accept expected 1 seen %b", write_accept_b);
      print_verdict();
    end else begin
      chk("read_accept_mode", shr, read_accept_b);
    end
  endtask
  initial begin
    logic [8:0]  cmd;
    logic [31:0] a;
    logic [15:0] m;
    int n;
    {rst_b, mem_wr_done, cache_overlap_busy, mlock} = 4'h0;
    n_errors = 0;
    checks = 0;
    mdly = 0;
    mcnt = 0;
    pattern_code = 4'h0;
    shared_addr_mode = 1'b0;
    foreach (rows[r]) begin
      do_reset(rows[r].pat, rows[r].shr);
      mdly = rows[r].dly;
      n = !rows[r].blk ? 1 : rows[r].code[1:0] == 2'h0 ? 2 : rows[r].code[1:0] == 2'h1 ? 4 : 8;
      cmd = {1'b0, CMD_OP_WRITE, rows[r].blk, 1'b0, rows[r].code};
      fork
        cpu.write_op(cmd, rows[r].ad, n + rows[r].extra, rows[r].gap);
        watch_mode(rows[r].shr);
      join
      wait_ret(n);
      repeat (24) @(negedge ref_clk);
      chk("retire_count", n, ret_a.size());
      chk("accept_freed", 1'b0, write_accept_b);
      m = ((16'h1 << (rows[r].code + 4'h1)) - 16'h1) << rows[r].ad[2:0];
      for (int i = 0; i < n; i++) begin
        a = rows[r].ad + 32'(8 * i);
        chk("mem_addr", a, ret_a[i]);
        chk("mem_data", {a, ~a}, ret_d[i]);
        chk("byte_en", rows[r].blk ? 8'hff : m[7:0], ret_b[i]);
      end
      $display("test row %0d done", r);
    end
    // cache read in flight holds retirement; a queued second block follows it
    do_reset(4'h9, 1'b0);
    cmd = {1'b0, 3'h1, 1'b1, 1'b0, 3'h0};
    cpu.write_op(cmd, 32'h6100, 0, 0);
    repeat (8) @(negedge ref_clk);
    chk("non_write_ignored", 1'b0, write_accept_b);
    cache_overlap_busy = 1'b1;
    cmd = {1'b0, CMD_OP_WRITE, 1'b1, 1'b0, 3'h0};
    cpu.write_op(cmd, 32'h6000, 2, 0);
    repeat (30) @(negedge ref_clk);
    chk("held_by_cache_read", 0, ret_a.size());
    cache_overlap_busy = 1'b0;
    cpu.write_op(cmd, 32'h7000, 2, 0);
    wait_ret(4);
    chk("second_block_start", 32'h7000, ret_a[2]);
    $display("test busy and back to back done");
    // reset lands mid-block while memory stalls
    mdly = 12;
    cmd = {1'b0, CMD_OP_WRITE, 1'b1, 1'b0, 3'h2};
    fork
      cpu.write_op(cmd, 32'h8000, 8, 0);
      begin
        repeat (14) @(negedge ref_clk);
        rst_b = 1'b0;
        @(negedge ref_clk);
        chk("accept_in_reset", 1'b1, write_accept_b);
        chk("req_in_reset", 1'b0, mem_wr_req);
        rst_b = 1'b1;
      end
    join
    repeat (4) @(negedge ref_clk);
    chk("accept_after_mid_reset", 1'b0, write_accept_b);
    $display("test mid-run reset done");
    chk("cpu_wait_limit", 0, cpu.timeouts);
    print_verdict();
  end
endmodule // wbc_write_buffer_tb_top
`default_nettype wire
